//--- rtl/flow_proc.v
// Overview of operation
// - Pressure smoothed by sliding average, window 1 to 50 seconds.
// - Average uses only samples inside the latest window.
// - Zero command captures reading as offset, subtracted afterwards.
// - Flow equals k-factor times square root of pressure.
// - Flow ceiling from k and full-scale root; flow clamped to it.
// - Measurement and control ranges limited between zero and ceiling.
// - Actual output scaled to measurement range, or control range.
// - Setpoint mapped onto control range low to high; an inverted range gives low.
// - Three tuning types: automatic, semi-automatic, manual.
// - Loop gain and control tolerance are adjustable.
// - Control pace follows actuator runtime from feedback line.
// - Sensor-only applications switch the control loop off.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "flow_proc_defs.vh"
module flow_proc #(
    parameter SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
    input  wire        clock,
    input  wire        reset_n,
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata,
    input  wire [15:0] pressure_in,
    input  wire        runtime_fb,
    output reg  [15:0] actual_out,
    output reg  [15:0] actuator_cmd,
    output reg         control_active
);
    // ****************************************
    // Registers
    // ****************************************
    reg         scale_ctrl_q;
    reg  [1:0]  tune_type_q;
    reg  [1:0]  app_q;
    reg  [5:0]  filter_sec_q;
    reg  [15:0] kfactor_q, nom_span_q, range_low_q, range_high_q;
    reg  [15:0] gain_q, tol_q, setpoint_in_q;
    reg  signed [16:0] offset_q;
    reg  [15:0] press_s1_q, press_s2_q, press_s3_q, press_q;
    reg         fb_s1_q, fb_s2_q, fb_prev_q;
    reg  [31:0] tick_cnt_q;
    reg  [15:0] win_q [0:49];
    reg  [21:0] sum_q;
    reg  [15:0] avg_q, flow_q, ceiling_q, set_flow_q;
    reg  [23:0] rt_cnt_q, runtime_q, pace_cnt_q;
    integer     i;
    integer     j;
    reg  [21:0] sum_d;

    // Integer square root, restoring method
    function [7:0] isqrt;
        input [15:0] v;
        reg   [15:0] rem;
        reg   [7:0]  root;
        integer      k;
        begin
            rem  = v;
            root = 8'h00;
            for (k = 7; k >= 0; k = k - 1) begin
                if ({8'h00, root | (8'h01 << k)} * {8'h00, root | (8'h01 << k)}
                    <= {16'h0000, rem})
                    root = root | (8'h01 << k);
            end
            isqrt = root;
        end
    endfunction

    // Clamp to ceiling, also limits configured ranges
    function [15:0] clamp;
        input [15:0] v;
        input [15:0] lim;
        begin
            clamp = (v > lim) ? lim : v;
        end
    endfunction

    // Linear map of value onto 0..FFFF over [lo,hi]
    function [15:0] scale;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        reg   [31:0] num;
        reg   [31:0] quo;
        begin
            if (hi <= lo || v <= lo)
                scale = 16'h0000;
            else if (v >= hi)
                scale = 16'hFFFF;
            else begin
                num   = {16'h0000, v - lo} * 32'h0000FFFF;
                quo   = num / {16'h0000, hi - lo};
                scale = quo[15:0];
            end
        end
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            press_s1_q <= 16'h0000;
            press_s2_q <= 16'h0000;
            press_s3_q <= 16'h0000;
            press_q    <= 16'h0000;
            fb_s1_q    <= 1'b0;
            fb_s2_q    <= 1'b0;
            fb_prev_q  <= 1'b0;
        end else begin
            press_s1_q <= pressure_in;
            press_s2_q <= press_s1_q;
            press_s3_q <= press_s2_q;
            // Multi-bit word: take it only once two samples agree
            // A word caught mid-change would skew the average
            if (press_s2_q == press_s3_q)
                press_q <= press_s2_q;
            fb_s1_q    <= runtime_fb;
            fb_s2_q    <= fb_s1_q;
            fb_prev_q  <= fb_s2_q;
        end
    end

    // Offset corrected pressure, negative floors at zero
    wire signed [17:0] corr_w = $signed({2'b00, press_q}) - offset_q;
    wire [15:0] press_pos_w = corr_w[17] ? 16'h0000 :
                              (corr_w[16] ? 16'hFFFF : corr_w[15:0]);
    wire        tick_w = (tick_cnt_q == SAMPLE_CYCLES - 1);
    wire        zero_cmd_w = wr && addr == `OFS_CTRL && wdata[`CTRL_ZERO_BIT];
    wire [5:0]  wlen_w = filter_sec_q;
    // Ceiling saturates rather than wrapping for very large k
    wire [23:0] ceil_full_w = {16'h0000, isqrt(`P_FULL_SCALE)} *
                              {8'h00, kfactor_q};
    wire [15:0] ceil_w = (|ceil_full_w[23:16]) ? 16'hFFFF
                         : ceil_full_w[15:0];
    wire [23:0] raw_flow_w = {16'h0000, isqrt(avg_q)} * {8'h00, kfactor_q};
    wire [21:0] avg_full_w = sum_q / {16'h0000, wlen_w};
    // Setpoint span; an inverted range collapses onto the low end
    wire [15:0] span_w = (range_high_q > range_low_q) ?
                         range_high_q - range_low_q : 16'h0000;
    wire [31:0] sp_prod_w = {16'h0000, setpoint_in_q} * {16'h0000, span_w};
    wire [31:0] sp_frac_w = sp_prod_w / 32'h0000FFFF;
    wire [15:0] set_raw_w = range_low_q + sp_frac_w[15:0];
    // Step size: auto uses a fixed step, the others the set gain
    wire [15:0] step_w = (tune_type_q == 2'd0) ? 16'h0001
                         : ({8'h00, gain_q[15:8]} + 16'h0001);
    // One spare bit so that none of the three sums can wrap
    wire [16:0] cmd_up_w = {1'b0, actuator_cmd} + {1'b0, step_w};
    wire [16:0] flow_hi_w = {1'b0, flow_q} + {1'b0, tol_q};
    wire [16:0] set_hi_w = {1'b0, set_flow_q} + {1'b0, tol_q};

    // ****************************************
    // Register writes
    // ****************************************
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            scale_ctrl_q  <= 1'b0;
            tune_type_q   <= 2'd0;
            app_q         <= 2'd0;
            filter_sec_q  <= `FILTER_RST;
            kfactor_q     <= `KFACTOR_RST;
            nom_span_q    <= 16'h0000;
            range_low_q   <= 16'h0000;
            range_high_q  <= 16'h0000;
            gain_q        <= `GAIN_RST;
            tol_q         <= `TOL_RST;
            setpoint_in_q <= 16'h0000;
            offset_q      <= 17'sh00000;
        end else begin
            if (zero_cmd_w)
                offset_q <= $signed({1'b0, press_q});
            if (wr) begin
                case (addr)
                    `OFS_CTRL: begin
                        scale_ctrl_q <= wdata[`CTRL_SCALE_BIT];
                        tune_type_q  <= wdata[`CTRL_TYPE_LSB +: 2];
                        app_q        <= wdata[`CTRL_APP_LSB +: 2];
                    end
                    `OFS_FILTER_SEC:
                        filter_sec_q <= (wdata[5:0] < `FILTER_MIN) ? `FILTER_MIN :
                            (wdata[5:0] > `FILTER_MAX) ? `FILTER_MAX : wdata[5:0];
                    `OFS_KFACTOR:     kfactor_q     <= wdata[15:0];
                    // Ranges clamp against the ceiling as it stands now
                    `OFS_NOM_SPAN:    nom_span_q    <= clamp(wdata[15:0], ceiling_q);
                    `OFS_RANGE_LOW:   range_low_q   <= clamp(wdata[15:0], ceiling_q);
                    `OFS_RANGE_HIGH:  range_high_q  <= clamp(wdata[15:0], ceiling_q);
                    `OFS_GAIN:        gain_q        <= wdata[15:0];
                    `OFS_TOLERANCE:   tol_q         <= wdata[15:0];
                    `OFS_SETPOINT_IN: setpoint_in_q <= wdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // Sliding average, one sample per second
    // ****************************************
    // Window sum rebuilt from the taps on every tick
    // Costs adders, but a shorter window drops old samples at once
    always @* begin
        sum_d = {6'h00, press_pos_w};
        for (j = 0; j < 49; j = j + 1) begin
            if (j < wlen_w - 1)
                sum_d = sum_d + {6'h00, win_q[j]};
        end
    end

    // Taps shift once per tick; the average follows a clock later
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_q <= 32'h00000000;
            sum_q      <= 22'h000000;
            avg_q      <= 16'h0000;
            for (i = 0; i < 50; i = i + 1)
                win_q[i] <= 16'h0000;
        end else begin
            tick_cnt_q <= tick_w ? 32'h00000000 : tick_cnt_q + 32'h00000001;
            if (tick_w) begin
                win_q[0] <= press_pos_w;
                for (i = 1; i < 50; i = i + 1)
                    win_q[i] <= win_q[i-1];
                sum_q <= sum_d;
            end
            avg_q <= avg_full_w[15:0];
        end
    end

    // ****************************************
    // Flow, ceiling, scaling, runtime pace
    // ****************************************
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ceiling_q  <= 16'h0000;
            flow_q     <= 16'h0000;
            set_flow_q <= 16'h0000;
            actual_out <= 16'h0000;
            rt_cnt_q   <= 24'h000000;
            runtime_q  <= `RUNTIME_MAX;
            pace_cnt_q <= 24'h000000;
            actuator_cmd   <= 16'h0000;
            control_active <= 1'b0;
        end else begin
            ceiling_q <= ceil_w;
            flow_q <= (raw_flow_w > {8'h00, ceiling_q}) ? ceiling_q
                      : raw_flow_w[15:0];
            set_flow_q <= clamp(set_raw_w, ceiling_q);
            actual_out <= scale_ctrl_q ? scale(flow_q, range_low_q, range_high_q)
                          : scale(flow_q, 16'h0000, nom_span_q);
            // Pulse period on feedback line reports actuator runtime
            if (fb_s2_q && !fb_prev_q) begin
                runtime_q <= rt_cnt_q;
                // Edge cycle itself counts, so the period reads whole
                rt_cnt_q  <= 24'h000001;
            end else if (rt_cnt_q != `RUNTIME_MAX)
                rt_cnt_q <= rt_cnt_q + 24'h000001;
            control_active <= (app_q == 2'd0 || app_q == 2'd2);
            if (!(app_q == 2'd0 || app_q == 2'd2))
                actuator_cmd <= 16'h0000;
            else if (pace_cnt_q >= (runtime_q >> 8)) begin
                pace_cnt_q <= 24'h000000;
                // Saturate: a wrap would slam the damper the wrong way
                if ({1'b0, set_flow_q} > flow_hi_w)
                    actuator_cmd <= cmd_up_w[16] ? 16'hFFFF
                                    : cmd_up_w[15:0];
                else if ({1'b0, flow_q} > set_hi_w && actuator_cmd != 16'h0000)
                    actuator_cmd <= actuator_cmd - 16'h0001;
            end else
                pace_cnt_q <= pace_cnt_q + 24'h000001;
        end
    end

    // ****************************************
    // Register reads, data one cycle later
    // ****************************************
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n)
            rdata <= 32'h00000000;
        else if (rd) begin
            case (addr)
                `OFS_CTRL:        rdata <= {26'h0, app_q, tune_type_q, scale_ctrl_q, 1'b0};
                `OFS_FILTER_SEC:  rdata <= {26'h0, filter_sec_q};
                `OFS_KFACTOR:     rdata <= {16'h0, kfactor_q};
                `OFS_NOM_SPAN:    rdata <= {16'h0, nom_span_q};
                `OFS_RANGE_LOW:   rdata <= {16'h0, range_low_q};
                `OFS_RANGE_HIGH:  rdata <= {16'h0, range_high_q};
                `OFS_GAIN:        rdata <= {16'h0, gain_q};
                `OFS_TOLERANCE:   rdata <= {16'h0, tol_q};
                `OFS_SETPOINT_IN: rdata <= {16'h0, setpoint_in_q};
                `OFS_STATUS:      rdata <= {31'h0, control_active};
                `OFS_FLOW:        rdata <= {16'h0, flow_q};
                `OFS_AVG:         rdata <= {16'h0, avg_q};
                `OFS_OFFSET:      rdata <= {{15{offset_q[16]}}, offset_q};
                `OFS_CEILING:     rdata <= {16'h0, ceiling_q};
                `OFS_ACT_OUT:     rdata <= {16'h0, actual_out};
                `OFS_SET_FLOW:    rdata <= {16'h0, set_flow_q};
                `OFS_RUNTIME:     rdata <= {8'h0, runtime_q};
                default:          rdata <= 32'h00000000;
            endcase
        end else
            rdata <= 32'h00000000;
    end
endmodule // flow_proc
`default_nettype wire

//--- rtl/flow_proc_defs.vh
`ifndef FLOW_PROC_DEFS_VH
`define FLOW_PROC_DEFS_VH
// ****************************************
// Register offsets
// ****************************************
`define OFS_CTRL        8'h00
`define OFS_FILTER_SEC  8'h04
`define OFS_KFACTOR     8'h08
`define OFS_NOM_SPAN    8'h0C
`define OFS_RANGE_LOW   8'h10
`define OFS_RANGE_HIGH  8'h14
`define OFS_GAIN        8'h18
`define OFS_TOLERANCE   8'h1C
`define OFS_SETPOINT_IN 8'h20
`define OFS_STATUS      8'h24
`define OFS_FLOW        8'h28
`define OFS_AVG         8'h2C
`define OFS_OFFSET      8'h30
`define OFS_CEILING     8'h34
`define OFS_ACT_OUT     8'h38
`define OFS_SET_FLOW    8'h3C
`define OFS_RUNTIME     8'h40
// ****************************************
// Control register fields
// ****************************************
`define CTRL_ZERO_BIT   0
`define CTRL_SCALE_BIT  1
`define CTRL_TYPE_LSB   2
`define CTRL_APP_LSB    4
// ****************************************
// Reset values and limits
// ****************************************
`define FILTER_MIN      6'd1
`define FILTER_MAX      6'd50
`define FILTER_RST      6'd20
`define KFACTOR_RST     16'h0064
`define GAIN_RST        16'h0100
`define TOL_RST         16'h0010
`define P_FULL_SCALE    16'h03E8
// ****************************************
// Timing
// ****************************************
`define CLK_HZ          200000000
`define SAMPLE_HZ       1
`define SAMPLE_CYCLES   (`CLK_HZ / `SAMPLE_HZ)
`define RUNTIME_MAX     24'hFFFFFF
`endif

//--- verif/flow_proc_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "flow_proc_defs.vh"
// ****
// Port checker
// ****
module flow_proc_chk (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic [15:0] actuator_cmd,
    input wire logic        control_active
);
    logic [15:0] k_q;
    logic [1:0]  app_q;
    wire         ctl_wr;
    wire  [31:0] ceil;
    // Shadow of k and application; ranges assumed written after k settles
    assign ctl_wr = wr && addr == `OFS_CTRL;
    // Ceiling saturates at the register width
    assign ceil = ({16'h0, k_q} * 32'h1F > 32'hFFFF) ? 32'hFFFF
                  : {16'h0, k_q} * 32'h1F;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            k_q <= `KFACTOR_RST;
            app_q <= 2'h0;
        end else begin
            if (wr && addr == `OFS_KFACTOR)
                k_q <= wdata[15:0];
            if (ctl_wr)
                app_q <= wdata[`CTRL_APP_LSB +: 2];
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    // Application write, then two cycles to settle
    sequence s_app_wr;
        ctl_wr ##1 !ctl_wr ##1 1'b1;
    endsequence
    sequence s_idle;
        (!control_active)[*3];
    endsequence
    sequence s_rd(a);
        rd && addr == a;
    endsequence
    property p_rd_idle; !rd |=> rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_unmapped; rd && addr > `OFS_RUNTIME |=> rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_filter;
        s_rd(`OFS_FILTER_SEC) |=> rdata >= 32'h1 && rdata <= 32'h32;
    endproperty
    a_filter: assert property (p_filter) else $error("window");
    property p_ceil; s_rd(`OFS_CEILING) |=> rdata == ceil; endproperty
    a_ceil: assert property (p_ceil) else $error("ceiling");
    property p_flow; s_rd(`OFS_FLOW) |=> rdata <= ceil; endproperty
    a_flow: assert property (p_flow) else $error("flow cap");
    property p_range;
        rd && (addr == `OFS_NOM_SPAN || addr == `OFS_RANGE_LOW ||
            addr == `OFS_RANGE_HIGH) |=> rdata <= ceil;
    endproperty
    a_range: assert property (p_range) else $error("range cap");
    property p_cmd_idle; s_idle |-> actuator_cmd == 16'h0; endproperty
    a_cmd_idle: assert property (p_cmd_idle) else $error("cmd");
    property p_active; s_app_wr |-> control_active == !app_q[0]; endproperty
    a_active: assert property (p_active) else $error("loop");
endmodule // flow_proc_chk
bind flow_proc flow_proc_chk chk (.clock(clock), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .actuator_cmd(actuator_cmd), .control_active(control_active));
`default_nettype wire

//--- verif/sensor_actuator_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Pressure sensor and damper feedback
// ****
module sensor_actuator_model (
    input wire logic        clock,
    input wire logic [15:0] level,
    input wire logic [15:0] period,
    output var logic [15:0] pressure_in = 16'h0,
    output var logic        runtime_fb = 1'b0
);
    logic [15:0] cnt_q = 16'h0;
    // Shorted ports give the bare offset; feedback edge once per runtime
    always @(posedge clock) begin
        pressure_in <= level;
        cnt_q <= (cnt_q + 16'h1 >= period) ? 16'h0 : cnt_q + 16'h1;
        runtime_fb <= cnt_q < (period >> 1);
    end
endmodule // sensor_actuator_model
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "flow_proc_defs.vh"
// ****
// Bench
// ****
module tb;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] level = 16'h0;
    logic [15:0] period = 16'h28;
    wire  [31:0] rdata;
    wire  [15:0] pressure_in;
    wire         runtime_fb;
    wire  [15:0] actual_out;
    wire  [15:0] actuator_cmd;
    wire         control_active;
    int          err_count = 0;
    int          n_compared = 0;
    int          cycles = 0;
    initial begin
        forever #2.5 clock = ~clock;
    end
    // Short sample period keeps each window a few cycles long
    flow_proc #(.SAMPLE_CYCLES(4)) dut (.clock(clock), .reset_n(reset_n),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pressure_in(pressure_in), .runtime_fb(runtime_fb),
        .actual_out(actual_out), .actuator_cmd(actuator_cmd),
        .control_active(control_active));
    sensor_actuator_model model (.clock(clock), .level(level),
        .period(period), .pressure_in(pressure_in), .runtime_fb(runtime_fb));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic get(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        cmp(rdata, exp);
    endtask
    // Fifteen samples: every window in use is full again
    task automatic settle;
        repeat (60) @(posedge clock);
    endtask
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Hang guard, far above the thousand or so cycles needed
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            test_done;
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        get(`OFS_FILTER_SEC, 32'h14);
        get(`OFS_CEILING, 32'hC1C);
        put(8'h80, 32'hFFFF);
        get(8'h80, 32'h0);
        put(`OFS_FILTER_SEC, 32'h0);
        get(`OFS_FILTER_SEC, 32'h1);
        put(`OFS_FILTER_SEC, 32'h33);
        get(`OFS_FILTER_SEC, 32'h32);
        put(`OFS_FILTER_SEC, 32'h1);
        $display("register test done");
        level <= 16'h7;
        settle;
        put(`OFS_CTRL, 32'h1);
        settle;
        get(`OFS_OFFSET, 32'h7);
        level <= 16'h6B;
        settle;
        get(`OFS_FLOW, 32'h3E8);
        level <= 16'h3;
        settle;
        get(`OFS_FLOW, 32'h0);
        level <= 16'h7D7;
        settle;
        get(`OFS_FLOW, 32'hC1C);
        put(`OFS_FILTER_SEC, 32'h2);
        level <= 16'h6B;
        settle;
        level <= 16'h197;
        settle;
        get(`OFS_FLOW, 32'h7D0);
        // Shrink the window back to one sample, then check flow after a full settle
        put(`OFS_FILTER_SEC, 32'h1);
        level <= 16'h6B;
        settle;
        get(`OFS_FLOW, 32'h3E8);
        level <= 16'h197;
        put(`OFS_KFACTOR, 32'hA);
        settle;
        get(`OFS_FLOW, 32'hC8);
        get(`OFS_CEILING, 32'h136);
        $display("flow test done");
        put(`OFS_RANGE_HIGH, 32'hFFFF);
        get(`OFS_RANGE_HIGH, 32'h136);
        put(`OFS_NOM_SPAN, 32'h100);
        get(`OFS_NOM_SPAN, 32'h100);
        put(`OFS_RANGE_LOW, 32'h50);
        put(`OFS_RANGE_HIGH, 32'h100);
        put(`OFS_SETPOINT_IN, 32'h0);
        settle;
        get(`OFS_SET_FLOW, 32'h50);
        put(`OFS_SETPOINT_IN, 32'hFFFF);
        settle;
        get(`OFS_SET_FLOW, 32'h100);
        put(`OFS_GAIN, 32'h200);
        get(`OFS_GAIN, 32'h200);
        put(`OFS_TOLERANCE, 32'h20);
        get(`OFS_TOLERANCE, 32'h20);
        // Flow 200 over measurement span 0..256, then control span 80..256
        cmp({16'h0, actual_out}, 32'hC7FF);
        put(`OFS_CTRL, 32'h2);
        repeat (3) @(posedge clock);
        @(negedge clock);
        cmp({16'h0, actual_out}, 32'hAE8A);
        $display("range test done");
        for (int app = 0; app < 4; app++) begin
            for (int ty = 0; ty < 3; ty++) begin
                put(`OFS_CTRL, 32'(app * 16 + ty * 4 + (ty & 1) * 2));
                repeat (3) @(posedge clock);
                @(negedge clock);
                cmp({31'h0, control_active}, 32'(app % 2 == 0));
                // Setpoint above flow plus tolerance: command must rise
                if (app % 2 == 0)
                    cmp({31'h0, actuator_cmd != 16'h0}, 32'h1);
            end
            if (app % 2 == 1)
                cmp({16'h0, actuator_cmd}, 32'h0);
        end
        get(`OFS_RUNTIME, 32'h28);
        period <= 16'h50;
        repeat (200) @(posedge clock);
        get(`OFS_RUNTIME, 32'h50);
        $display("mode test done");
        test_done;
    end
endmodule // tb
`default_nettype wire
